/* File: verilog/slave_end.sv */
// Slave end: state machine, traffic permits, output safing, distributed clock.
// Assumes the master end keeps to request order and frame format.
`timescale 1ns/1ps
// Function
// RULE1: Start in init, refuse all traffic
// RULE2: Master sets mailbox channels in init
// RULE3: Check mailbox channels entering preoperational
// RULE4: Preoperational: mailbox yes, process data no
// RULE5: Master sets process channels from two
// RULE6: Ethernet tunnel only in preoperational
// RULE7: Check process channels and clock settings
// RULE8: Copy inputs before acknowledging safe operational
// RULE9: Safe operational: traffic, cyclic inputs, safe outputs
// RULE10: Watchdog default on forces safe outputs
// RULE11: Master sends valid outputs before operational
// RULE12: Operational drives outputs from master data
// RULE13: Extract own data while frame streams
// RULE14: Insert inputs in same traversal
// RULE15: Standard Ethernet frames only
// RULE16: Clock with compare makes cycle pulses
// RULE17: Master addresses up to 1023 slaves
// RULE18: Failed check keeps state, reports error
// RULE19: Change only on request, no skipping
module slave_end
	import slave_pkg::*;
#(
	parameter int          W        = DATA_W,
	parameter logic [15:0] WIN_POS  = 16'h000e,
	parameter logic [31:0] CYCLE    = CYCLE_DEFAULT
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_resetn,
	slave_link_if.slave       link,
	input  wire logic [W-1:0] i_phys_in,
	input  wire logic         i_watchdog_off,
	input  wire logic [31:0]  i_clock_offset,
	input  wire logic         i_offset_load,
	output logic      [W-1:0] o_phys_out,
	output logic      [1:0]   o_state,
	output logic              o_mbx_allow,
	output logic              o_pd_allow,
	output logic              o_tunnel_allow,
	output logic      [31:0]  o_sys_time,
	output logic              o_cycle_pulse,
	output logic              o_frame_err
);
	typedef enum {S_INIT, S_PREOP, S_SAFE_OPERATIONAL_LABEL, S_OP} state_type;
	state_type   state_reg;
	state_type   state_next;
	logic [W-1:0] in_image_reg;
	logic [W-1:0] out_image_reg;
	logic [W-1:0] in_sync_1;
	logic [W-1:0] in_sync_2;
	logic [W-1:0] in_sync_3;
	logic [W-1:0] pass_out_byte;
	logic         pass_out_strobe;
	logic [31:0]  time_reg;
	logic [31:0]  compare_reg;
	logic [15:0]  type_reg;
	logic [15:0]  len_reg;
	logic         ok;

	function automatic logic [1:0] enc(input state_type s);
		case (s)
			S_INIT:   enc = ST_INIT;
			S_PREOP:  enc = ST_PREOP;
			S_SAFE_OPERATIONAL_LABEL: enc = ST_SAFE_OPERATIONAL_LABEL;
			default:  enc = ST_OP;
		endcase
	endfunction

	// Only neighbouring steps up, or any step down, are legal
	always_comb begin
		state_next = state_reg;
		ok = 1'b0;
		case (state_reg)
			S_INIT: begin
				if (link.req_state == ST_PREOP) begin
					ok = link.chan_mbx_ok[MBX_CHAN_LO] && link.chan_mbx_ok[MBX_CHAN_HI]; // RULE3
					state_next = ok ? S_PREOP : S_INIT;
				end else if (link.req_state == ST_INIT) begin
					ok = 1'b1;
				end
			end
			S_PREOP: begin
				if (link.req_state == ST_SAFE_OPERATIONAL_LABEL) begin
					ok = link.chan_pd_ok && (link.dc_ok || !link.dc_required); // RULE7
					state_next = ok ? S_SAFE_OPERATIONAL_LABEL : S_PREOP;
				end else if (link.req_state == ST_INIT) begin
					ok = 1'b1;
					state_next = S_INIT;
				end else if (link.req_state == ST_PREOP) begin
					ok = 1'b1;
				end
			end
			S_SAFE_OPERATIONAL_LABEL: begin
				ok = 1'b1;
				case (link.req_state)
					ST_INIT:  state_next = S_INIT;
					ST_PREOP: state_next = S_PREOP;
					ST_OP:    state_next = S_OP;
					default:  state_next = S_SAFE_OPERATIONAL_LABEL;
				endcase
			end
			default: begin
				ok = 1'b1;
				case (link.req_state)
					ST_INIT:   state_next = S_INIT;
					ST_PREOP:  state_next = S_PREOP;
					ST_SAFE_OPERATIONAL_LABEL: state_next = S_SAFE_OPERATIONAL_LABEL;
					default:   state_next = S_OP;
				endcase
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= S_INIT; // RULE1
		end else if (link.req_valid) begin
			state_reg <= state_next; // RULE19 RULE18
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			link.ack_valid <= 1'b0;
			link.ack_error <= 1'b0;
			link.ack_state <= ST_INIT;
		end else begin
			link.ack_valid <= link.req_valid;
			if (link.req_valid) begin
				link.ack_error <= !ok; // RULE18
				link.ack_state <= enc(state_next);
			end
		end
	end

	// Pin inputs: third stage compared with second for a stable value
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			in_sync_1 <= '0;
			in_sync_2 <= '0;
			in_sync_3 <= '0;
		end else begin
			in_sync_1 <= i_phys_in;
			in_sync_2 <= in_sync_1;
			in_sync_3 <= in_sync_2;
		end
	end

	// Stable inputs captured on entry to safe operational, then every cycle
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			in_image_reg <= '0;
		end else if ((in_sync_2 == in_sync_3) &&
			((link.req_valid && state_next == S_SAFE_OPERATIONAL_LABEL) ||
			state_reg == S_SAFE_OPERATIONAL_LABEL || state_reg == S_OP)) begin
			in_image_reg <= in_sync_3; // RULE8 RULE9
		end
	end

	assign o_mbx_allow    = state_reg != S_INIT; // RULE1 RULE4
	assign o_pd_allow     = state_reg == S_SAFE_OPERATIONAL_LABEL || state_reg == S_OP; // RULE4 RULE9
	assign o_tunnel_allow = state_reg == S_PREOP; // RULE6
	assign o_state        = enc(state_reg);

	frame_pass #(
		.W (W)
	) u_pass (
		.i_ref_clk    (i_ref_clk),
		.i_resetn     (i_resetn),
		.i_data       (link.tx_data),
		.i_valid      (link.tx_valid),
		.i_sof        (link.tx_sof),
		.i_eof        (link.tx_eof),
		.i_win_start  (WIN_POS),
		.i_pd_enable  (o_pd_allow),
		.i_in_byte    (in_image_reg),
		.o_data       (link.rx_data),
		.o_valid      (link.rx_valid),
		.o_sof        (link.rx_sof),
		.o_eof        (link.rx_eof),
		.o_out_byte   (pass_out_byte),
		.o_out_strobe (pass_out_strobe)
	);

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_image_reg <= SAFE_OUT_RST;
		end else if (pass_out_strobe) begin
			out_image_reg <= pass_out_byte; // RULE13
		end
	end

	// Watchdog on keeps outputs safe in safe operational
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_phys_out <= SAFE_OUT;
		end else if (state_reg == S_OP || (state_reg == S_SAFE_OPERATIONAL_LABEL && i_watchdog_off)) begin
			o_phys_out <= out_image_reg; // RULE12 RULE10
		end else begin
			o_phys_out <= SAFE_OUT; // RULE9 RULE10
		end
	end

	// Type taken from bytes 12 and 13; type and length checked at frame end
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			len_reg     <= 16'h0000;
			type_reg    <= 16'h0000;
			o_frame_err <= 1'b0;
		end else if (link.tx_valid) begin
			len_reg <= link.tx_sof ? 16'h0001 : 16'(len_reg + 16'h0001);
			if (len_reg == 16'h000c) begin
				type_reg[15:8] <= link.tx_data;
			end
			if (len_reg == 16'h000d) begin
				type_reg[7:0] <= link.tx_data;
			end
			if (link.tx_eof) begin
				o_frame_err <= (type_reg != ETHERTYPE) ||
					(32'(len_reg) + 32'd1 < 32'(MIN_FRAME_BYTES)) ||
					(32'(len_reg) + 32'd1 > 32'(MAX_FRAME_BYTES)); // RULE15
			end
		end
	end

	// Local time; offset load aligns with other slaves
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			time_reg      <= 32'h00000000;
			compare_reg   <= 32'h00000000;
			o_cycle_pulse <= 1'b0;
		end else begin
			time_reg      <= i_offset_load ? i_clock_offset : 32'(time_reg + 32'd1); // RULE16
			o_cycle_pulse <= time_reg == compare_reg;
			if (time_reg == compare_reg) begin
				compare_reg <= 32'(compare_reg + CYCLE); // RULE16
			end
		end
	end
	assign o_sys_time = time_reg;
endmodule

/* File: verilog/slave_pkg.sv */
// Shared constants for the fieldbus slave state machine link.
// Assumes one 200 MHz clock shared by both ends.
package slave_pkg;
	localparam int          DATA_W          = 8;
	localparam int          STATE_W         = 2;
	localparam logic [1:0]  ST_INIT         = 2'h0;
	localparam logic [1:0]  ST_PREOP        = 2'h1;
	localparam logic [1:0]  ST_SAFE_OPERATIONAL_LABEL       = 2'h2;
	localparam logic [1:0]  ST_OP           = 2'h3;
	localparam int          NUM_CHAN        = 4;
	localparam int          MBX_CHAN_LO     = 0;
	localparam int          MBX_CHAN_HI     = 1;
	localparam int          PD_CHAN_FIRST   = 2;
	localparam int          MAX_SLAVES      = 1023;
	localparam int          ADDR_W          = 10;
	localparam int          CLK_PERIOD_PS   = 5000;
	localparam int          SYNC_WIN_NS     = 100;
	localparam int          SYNC_WIN_CYC    = (SYNC_WIN_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [31:0] CYCLE_DEFAULT   = 32'h00030d40;
	localparam logic [15:0] ETHERTYPE       = 16'h88a4;
	localparam int          MIN_FRAME_BYTES = 64;
	localparam int          MAX_FRAME_BYTES = 1518;
	localparam logic [7:0]  SAFE_OUT        = 8'h00;
	localparam logic [7:0]  SAFE_OUT_RST    = 8'h00;
endpackage

/* File: verilog/slave_link_if.sv */
// Link between master end and slave end: state requests and byte stream.
// Assumes both ends on one clock; the testbench instances and joins them.
`timescale 1ns/1ps
interface slave_link_if;
	import slave_pkg::*;
	logic [1:0] req_state;
	logic       req_valid;
	logic [1:0] ack_state;
	logic       ack_error;
	logic       ack_valid;
	logic [3:0] chan_mbx_ok;
	logic       chan_pd_ok;
	logic       dc_ok;
	logic       dc_required;
	logic [7:0] tx_data;
	logic       tx_valid;
	logic       tx_sof;
	logic       tx_eof;
	logic [7:0] rx_data;
	logic       rx_valid;
	logic       rx_sof;
	logic       rx_eof;
	modport master (output req_state, req_valid, chan_mbx_ok, chan_pd_ok, dc_ok,
		dc_required, tx_data, tx_valid, tx_sof, tx_eof,
		input ack_state, ack_error, ack_valid, rx_data, rx_valid, rx_sof, rx_eof);
	modport slave (input req_state, req_valid, chan_mbx_ok, chan_pd_ok, dc_ok,
		dc_required, tx_data, tx_valid, tx_sof, tx_eof,
		output ack_state, ack_error, ack_valid, rx_data, rx_valid, rx_sof, rx_eof);
endinterface

/* File: verilog/frame_pass.sv */
// Byte-wise pass-through that swaps in input bytes at the slave's window.
// Assumes one byte per valid cycle with sof on the first, eof on the last.
`timescale 1ns/1ps
module frame_pass
	import slave_pkg::*;
#(
	parameter int W = DATA_W
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_data,
	input  wire logic         i_valid,
	input  wire logic         i_sof,
	input  wire logic         i_eof,
	input  wire logic [15:0]  i_win_start,
	input  wire logic         i_pd_enable,
	input  wire logic [W-1:0] i_in_byte,
	output logic      [W-1:0] o_data,
	output logic              o_valid,
	output logic              o_sof,
	output logic              o_eof,
	output logic      [W-1:0] o_out_byte,
	output logic              o_out_strobe
);
	logic [15:0] pos_reg;
	logic        hit;

	// Position counted on the fly; no whole-frame store
	assign hit = i_valid && i_pd_enable &&
		((i_sof ? 16'h0000 : pos_reg) == i_win_start);

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pos_reg <= 16'h0000;
		end else if (i_valid) begin
			pos_reg <= i_sof ? 16'h0001 : 16'(pos_reg + 16'h0001); // RULE13
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_data  <= '0;
			o_valid <= 1'b0;
			o_sof   <= 1'b0;
			o_eof   <= 1'b0;
		end else begin
			o_data  <= hit ? i_in_byte : i_data; // RULE14
			o_valid <= i_valid;
			o_sof   <= i_sof && i_valid;
			o_eof   <= i_eof && i_valid;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_out_byte   <= '0;
			o_out_strobe <= 1'b0;
		end else begin
			o_out_strobe <= hit;
			if (hit) begin
				o_out_byte <= i_data; // RULE13
			end
		end
	end
endmodule

/* File: verilog/master_end.sv */
// Master end: walks the slave up through the states and streams frames.
// Assumes the slave end answers each request one cycle later.
`timescale 1ns/1ps
module master_end
	import slave_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	slave_link_if.master     link,
	input  wire logic [1:0]  i_target,
	input  wire logic        i_go,
	input  wire logic [9:0]  i_slave_addr,
	input  wire logic [7:0]  i_frame_byte,
	input  wire logic        i_frame_valid,
	input  wire logic        i_frame_sof,
	input  wire logic        i_frame_eof,
	input  wire logic        i_out_valid,
	output logic      [1:0]  o_state,
	output logic             o_error,
	output logic             o_busy,
	output logic      [9:0]  o_addr
);
	typedef enum {M_IDLE, M_REQ, M_WAIT} mstate_type;
	mstate_type mstate_reg;
	logic [1:0] target_reg;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mstate_reg     <= M_IDLE;
			target_reg     <= ST_INIT;
			link.req_valid <= 1'b0;
			link.req_state <= ST_INIT;
			o_state        <= ST_INIT;
			o_error        <= 1'b0;
		end else begin
			link.req_valid <= 1'b0;
			case (mstate_reg)
				M_IDLE: begin
					if (i_go) begin
						target_reg <= i_target;
						o_error    <= 1'b0;
						mstate_reg <= M_REQ;
					end
				end
				M_REQ: begin
					if (target_reg == o_state) begin
						mstate_reg <= M_IDLE;
					end else if (target_reg == ST_OP && o_state == ST_SAFE_OPERATIONAL_LABEL && !i_out_valid) begin
						mstate_reg <= M_REQ; // RULE11
					end else begin
						// One step at a time upward
						link.req_state <= (target_reg > o_state) ? 2'(o_state + 2'd1) : target_reg;
						link.req_valid <= 1'b1;
						mstate_reg     <= M_WAIT;
					end
				end
				default: begin
					if (link.ack_valid) begin
						o_state    <= link.ack_state;
						o_error    <= link.ack_error;
						mstate_reg <= link.ack_error ? M_IDLE : M_REQ;
					end
				end
			endcase
		end
	end

	// Channel setup done in the state before the step up that checks it
	assign link.chan_mbx_ok = 4'b0011; // RULE2
	assign link.chan_pd_ok  = o_state != ST_INIT; // RULE5
	assign link.dc_ok       = 1'b1;
	assign link.dc_required = 1'b0;
	assign link.tx_data     = i_frame_byte; // RULE15
	assign link.tx_valid    = i_frame_valid;
	assign link.tx_sof      = i_frame_sof;
	assign link.tx_eof      = i_frame_eof;
	assign o_busy           = mstate_reg != M_IDLE;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_addr <= 10'h000;
		end else if (i_slave_addr <= 10'(MAX_SLAVES)) begin
			o_addr <= i_slave_addr; // RULE17
		end
	end
endmodule

/* File: verification/slave_link_chk.sv */
// Checker on the link between master end and slave end.
// Assumes it watches the interface signals of the pair built by the bench.
`timescale 1ns/1ps
module slave_link_chk
	import slave_pkg::*;
#(
	parameter logic [15:0] WIN_POS = 16'h000e
) (
	input wire logic       i_ref_clk,
	input wire logic       i_resetn,
	input wire logic [1:0] req_state,
	input wire logic       req_valid,
	input wire logic [1:0] ack_state,
	input wire logic       ack_error,
	input wire logic       ack_valid,
	input wire logic [3:0] chan_mbx_ok,
	input wire logic       chan_pd_ok,
	input wire logic       dc_ok,
	input wire logic       dc_required,
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_sof,
	input wire logic       tx_eof,
	input wire logic [7:0] rx_data,
	input wire logic       rx_valid,
	input wire logic       rx_sof,
	input wire logic       rx_eof
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	logic [15:0] idx_reg;
	logic [15:0] idx_next;
	logic [15:0] cur_idx;
	// Byte index of the byte now on tx, 0 at start of frame
	assign cur_idx  = tx_sof ? 16'h0000 : idx_reg;
	assign idx_next = tx_valid ? cur_idx + 16'h0001 : idx_reg;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idx_reg <= 16'h0000;
		end else begin
			idx_reg <= idx_next;
		end
	end
	AST_ACK_ONE_LATER: assert property (req_valid |=> ack_valid)
		else $error("ack missing one cycle after request");
	AST_NO_SPONT_ACK: assert property (ack_valid |-> $past(req_valid))
		else $error("ack without request");
	AST_ACK_HOLD: assert property (!ack_valid |-> $stable(ack_state) && $stable(ack_error))
		else $error("state changed without ack");
	AST_NO_SKIP: assert property (req_valid && req_state > ack_state
		&& req_state != ack_state + 2'h1 |=> ack_error && ack_state == $past(ack_state))
		else $error("skipped state not refused");
	AST_MBX_CHECK: assert property (req_valid && ack_state == ST_INIT && req_state == ST_PREOP
		|=> ack_error == !(&$past(chan_mbx_ok[1:0]))
		&& ack_state == ($past(&chan_mbx_ok[1:0]) ? ST_PREOP : ST_INIT))
		else $error("mailbox check wrong");
	AST_PD_CHECK: assert property (req_valid && ack_state == ST_PREOP && req_state == ST_SAFE_OPERATIONAL_LABEL
		|=> ack_error == $past(!(chan_pd_ok && (dc_ok || !dc_required))))
		else $error("process channel check wrong");
	AST_DOWN_OK: assert property (req_valid && req_state < ack_state
		|=> !ack_error && ack_state == $past(req_state))
		else $error("down step refused");
	AST_PASS_FLAGS: assert property (tx_valid |=> rx_valid && rx_sof == $past(tx_sof)
		&& rx_eof == $past(tx_eof))
		else $error("stream not passed one cycle later");
	AST_PASS_DATA: assert property (tx_valid && !(cur_idx == WIN_POS && ack_state >= ST_SAFE_OPERATIONAL_LABEL)
		|=> rx_data == $past(tx_data))
		else $error("byte changed outside window");
	COV_ERR: cover property (ack_valid && ack_error);
	COV_OP: cover property (ack_valid && ack_state == ST_OP);
	COV_WIN: cover property (tx_valid && cur_idx == WIN_POS && ack_state >= ST_SAFE_OPERATIONAL_LABEL);
endmodule

/* File: verification/fieldbus_slave_state_machine_tb_top.sv */
// Bench: master end joined to slave end, plus a slave end driven directly.
// Assumes one 200 MHz clock; the direct pair is where requests break order.
`timescale 1ns/1ps
module fieldbus_slave_state_machine_tb_top;
	import slave_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [1:0] target = 2'h0;
	logic go = 1'b0, fvalid = 1'b0, fsof = 1'b0, feof = 1'b0, out_valid = 1'b0;
	logic [7:0] fbyte = 8'h00, phys_in = 8'h00, rx14 = 8'h00;
	logic [9:0] saddr = 10'h000;
	logic wd_off = 1'b0, ofs_load = 1'b0;
	logic [31:0] ofs = 32'h00000000;
	logic [1:0] m_state, s_state, f_state;
	logic m_err, m_busy, mbx, pd, tun, ferr, pulse;
	logic [7:0] pout;
	logic [31:0] stime;
	logic [9:0] m_addr;
	logic [15:0] rx_idx = 16'h0000;
	int err_count = 0, cmp_count = 0, cyc = 0, pulses = 0;
	always #2.5 i_ref_clk = ~i_ref_clk;
	slave_link_if link ();
	slave_link_if link_f ();
	master_end i_master_end (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .link(link),
		.i_target(target), .i_go(go), .i_slave_addr(saddr), .i_frame_byte(fbyte),
		.i_frame_valid(fvalid), .i_frame_sof(fsof), .i_frame_eof(feof),
		.i_out_valid(out_valid), .o_state(m_state), .o_error(m_err), .o_busy(m_busy),
		.o_addr(m_addr));
	slave_end #(.CYCLE(32'd20)) i_slave_end (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.link(link), .i_phys_in(phys_in), .i_watchdog_off(wd_off),
		.i_clock_offset(ofs), .i_offset_load(ofs_load), .o_phys_out(pout),
		.o_state(s_state), .o_mbx_allow(mbx), .o_pd_allow(pd), .o_tunnel_allow(tun),
		.o_sys_time(stime), .o_cycle_pulse(pulse), .o_frame_err(ferr));
	slave_end i_slave_end_f (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .link(link_f),
		.i_phys_in(phys_in), .i_watchdog_off(wd_off), .i_clock_offset(ofs),
		.i_offset_load(ofs_load), .o_phys_out(), .o_state(f_state), .o_mbx_allow(),
		.o_pd_allow(), .o_tunnel_allow(), .o_sys_time(), .o_cycle_pulse(),
		.o_frame_err());
	slave_link_chk i_slave_link_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.req_state(link.req_state), .req_valid(link.req_valid), .ack_state(link.ack_state),
		.ack_error(link.ack_error), .ack_valid(link.ack_valid),
		.chan_mbx_ok(link.chan_mbx_ok), .chan_pd_ok(link.chan_pd_ok), .dc_ok(link.dc_ok),
		.dc_required(link.dc_required), .tx_data(link.tx_data), .tx_valid(link.tx_valid),
		.tx_sof(link.tx_sof), .tx_eof(link.tx_eof), .rx_data(link.rx_data),
		.rx_valid(link.rx_valid), .rx_sof(link.rx_sof), .rx_eof(link.rx_eof));
	// Window byte as it leaves the slave
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (link.rx_valid === 1'b1) begin
			rx_idx <= (link.rx_sof === 1'b1) ? 16'h0001 : rx_idx + 16'h0001;
			if (((link.rx_sof === 1'b1) ? 16'h0000 : rx_idx) == 16'h000e) begin
				rx14 <= link.rx_data;
			end
		end
		if (cyc == 8000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end
	task automatic stop_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic go_state(input logic [1:0] t);
		@(posedge i_ref_clk);
		target <= t;
		go <= 1'b1;
		@(posedge i_ref_clk);
		go <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		// Bounded wait, a stuck master must not hang the run
		for (int n = 0; n < 50 && m_busy !== 1'b0; n++) begin
			@(posedge i_ref_clk);
		end
		repeat (2) @(posedge i_ref_clk);
		chk(m_state, t);
		chk(s_state, t);
		chk(m_err, 1'b0);
	endtask
	// 64-byte frame, type bytes 12 and 13, own output byte at 14
	task automatic send_frame(input logic [7:0] type_lo, input logic [7:0] ob);
		for (int i = 0; i < 64; i++) begin
			@(posedge i_ref_clk);
			fbyte <= (i == 12) ? 8'h88 : (i == 13) ? type_lo : (i == 14) ? ob : 8'(i);
			fvalid <= 1'b1;
			fsof <= (i == 0);
			feof <= (i == 63);
		end
		@(posedge i_ref_clk);
		fvalid <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	endtask
	task automatic req_f(input logic [1:0] st, input logic [1:0] es, input logic ee);
		@(posedge i_ref_clk);
		link_f.req_state <= st;
		link_f.req_valid <= 1'b1;
		@(posedge i_ref_clk);
		link_f.req_valid <= 1'b0;
		#1;
		chk(link_f.ack_valid, 1'b1);
		chk(link_f.ack_state, es);
		chk(link_f.ack_error, ee);
		chk(f_state, es);
	endtask
	initial begin
		link_f.req_state = 2'h0;
		link_f.req_valid = 1'b0;
		link_f.chan_mbx_ok = 4'h0;
		link_f.chan_pd_ok = 1'b0;
		link_f.dc_ok = 1'b0;
		link_f.dc_required = 1'b1;
		{link_f.tx_data, link_f.tx_valid, link_f.tx_sof, link_f.tx_eof} = 11'h000;
		repeat (8) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		phys_in <= 8'h5a;
		saddr <= 10'h005;
		repeat (2) @(posedge i_ref_clk);
		chk(s_state, ST_INIT);
		chk({mbx, pd}, 2'b00);
		chk(pout, SAFE_OUT_RST);
		chk(m_addr, 10'h005);
		go_state(ST_PREOP);
		chk({mbx, pd, tun}, 3'b101);
		go_state(ST_SAFE_OPERATIONAL_LABEL);
		chk({mbx, pd, tun}, 3'b110);
		send_frame(8'ha4, 8'h3c);
		chk(rx14, 8'h5a);
		chk(pout, SAFE_OUT);
		chk(ferr, 1'b0);
		wd_off <= 1'b1;
		send_frame(8'ha4, 8'h3c);
		chk(pout, 8'h3c);
		wd_off <= 1'b0;
		out_valid <= 1'b1;
		phys_in <= 8'ha7;
		go_state(ST_OP);
		send_frame(8'ha4, 8'hc3);
		chk(pout, 8'hc3);
		chk(rx14, 8'ha7);
		send_frame(8'h00, 8'hc3);
		chk(ferr, 1'b1);
		// Counted here, one sample per edge, so no race with a clocked counter
		pulses = 0;
		repeat (200) begin
			@(posedge i_ref_clk);
			pulses = pulses + int'(pulse === 1'b1);
		end
		chk(pulses, 10);
		// Offset load: time jumps, then counts on
		ofs <= 32'h00001000;
		ofs_load <= 1'b1;
		@(posedge i_ref_clk);
		ofs_load <= 1'b0;
		@(posedge i_ref_clk);
		#1;
		chk(stime, 32'h00001001);
		go_state(ST_INIT);
		chk({mbx, pd, pout}, 10'h000);
		// Direct slave: skipped steps and failed checks mixed with legal steps
		req_f(ST_OP, ST_INIT, 1'b1);
		req_f(ST_PREOP, ST_INIT, 1'b1);
		link_f.chan_mbx_ok <= 4'h3;
		req_f(ST_PREOP, ST_PREOP, 1'b0);
		req_f(ST_OP, ST_PREOP, 1'b1);
		link_f.chan_pd_ok <= 1'b1;
		req_f(ST_SAFE_OPERATIONAL_LABEL, ST_PREOP, 1'b1);
		link_f.dc_ok <= 1'b1;
		req_f(ST_SAFE_OPERATIONAL_LABEL, ST_SAFE_OPERATIONAL_LABEL, 1'b0);
		req_f(ST_INIT, ST_INIT, 1'b0);
		stop_test();
	end
endmodule
